/* pkg/mute_regs_pkg.sv */
// Package: offsets, reset values and ramp timing for the soft-mute register bank
package mute_regs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          CHANNELS        = 8;
  localparam logic [6:0]  MUTE_CTRL_ADDR  = 7'h44;
  localparam logic [6:0]  ZERO_STAT_ADDR  = 7'h45;
  localparam logic [7:0]  MUTE_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Attenuator coding: 0 is unity, ATTEN_INF is infinite attenuation
  // ----------------------------------------------------------------
  localparam int          ATTEN_W         = 8;
  localparam logic [7:0]  ATTEN_INF       = 8'hFF;
  localparam logic [7:0]  ATTEN_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Ramp timing: one attenuator step every STEP_TIME_NS
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          STEP_TIME_NS    = 1000;
  localparam int          STEP_CYCLES     = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_HOLD, ST_DOWN, ST_UP} ramp_state_type;

endpackage : mute_regs_pkg

/* rtl/channel_ramp.sv */
// Module: one channel's attenuator that also carries the soft-mute ramp
`timescale 1ns/1ps
module channel_ramp #(
  parameter int ATTEN_W = 8
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Control
  input  wire logic               step_en,
  input  wire logic               mute,
  input  wire logic [ATTEN_W-1:0] target_level,
  // Applied attenuation
  output logic      [ATTEN_W-1:0] atten
);

  // ----------------------------------------------------------------
  // Goal selection
  // ----------------------------------------------------------------
  // Mute overrides the programmed level; unmute returns to it
  wire logic [ATTEN_W-1:0] goal      = mute ? mute_regs_pkg::ATTEN_INF : target_level; // R6
  wire logic               go_down   = atten < goal;
  wire logic               go_up     = atten > goal;
  wire logic [ATTEN_W-1:0] next_atten =
    !step_en ? atten :
    go_down  ? ATTEN_W'(atten + 1'b1) :   // R3
    go_up    ? ATTEN_W'(atten - 1'b1) :   // R4
    atten;

  // Single step per enable so mute and unmute share the same slope
  always_ff @(posedge clk)
  begin
    if (rst)
      atten <= mute_regs_pkg::ATTEN_RESET;
    else
      atten <= next_atten; // R5
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_step_size: assert property (@(posedge clk) disable iff (rst) // R3
    !$stable(atten) |-> ($past(atten) - atten == 1 || atten - $past(atten) == 1))
    else $error("attenuator jumped by more than one step");

  chk_muted_hold: assert property (@(posedge clk) disable iff (rst) // R6
    (mute && atten == mute_regs_pkg::ATTEN_INF) |=> atten == mute_regs_pkg::ATTEN_INF)
    else $error("muted output left infinite attenuation");

  // Muted channel below infinite attenuation must descend on every step
  chk_mute_descend: assert property (@(posedge clk) disable iff (rst) // R3
    (step_en && mute && atten < mute_regs_pkg::ATTEN_INF) |=> atten == ATTEN_W'($past(atten) + 1'b1))
    else $error("muted channel did not step down");

  // Unmuted channel above its level must climb back on every step
  chk_unmute_ascend: assert property (@(posedge clk) disable iff (rst) // R4
    (step_en && !mute && atten > target_level) |=> atten == ATTEN_W'($past(atten) - 1'b1))
    else $error("unmuted channel did not step back");

  chk_no_step_idle: assert property (@(posedge clk) disable iff (rst) // R5
    !$past(step_en) |-> $stable(atten))
    else $error("attenuator moved without step enable");

endmodule : channel_ramp

/* rtl/soft_mute_zero_flag_regs.sv */
// Module: soft-mute control and zero-flag status registers with per-channel ramps
// ------------------------------------------------------------------
// Notes on behaviour
// R1 - Eight mute bits at 0x44, bit 0 channel 1 up to bit 7 channel 8.
// R2 - Mute bit clear: channel uses programmed attenuation normally.
// R3 - Mute bit set: attenuation steps gradually down to infinite attenuation.
// R4 - Mute bit cleared: attenuation ramps back to programmed level, same manner.
// R5 - Ramp uses the same attenuator that applies the level.
// R6 - While muted, level writes cannot unmute or change the output.
// R7 - Reset clears all mute bits, every channel unmuted.
// R8 - Zero flags at 0x45 show live detector state, bit 0 channel 1.
// R9 - Zero-flag register is read-only.
// R10 - Zero flag reads 1 when zero input detected, else 0.
// R11 - Writes to the zero-flag register are ignored silently.
// ------------------------------------------------------------------
`timescale 1ns/1ps
module soft_mute_zero_flag_regs #(
  parameter int CHANNELS    = mute_regs_pkg::CHANNELS,
  parameter int ATTEN_W     = mute_regs_pkg::ATTEN_W,
  parameter int STEP_CYCLES = mute_regs_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Register port from the serial control decoder (same clock)
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [6:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_hit,
  // Programmed levels from the attenuation-level registers
  input  wire logic [CHANNELS*ATTEN_W-1:0] level_in,
  // Zero-input detectors, one per channel (same clock)
  input  wire logic [CHANNELS-1:0]         zero_detect,
  // Applied attenuation and mute state per channel
  output logic      [CHANNELS*ATTEN_W-1:0] atten_out,
  output logic      [CHANNELS-1:0]         channel_mute_bits
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic sel_mute = reg_addr == mute_regs_pkg::MUTE_CTRL_ADDR;
  wire logic sel_zero = reg_addr == mute_regs_pkg::ZERO_STAT_ADDR;
  wire logic wr_mute  = reg_wr && sel_mute; // R1
  // A write to the zero flags has no path to any storage
  wire logic wr_zero  = reg_wr && sel_zero; // R11

  wire logic [7:0] next_rdata =
    sel_mute ? 8'(channel_mute_bits) :
    sel_zero ? 8'(zero_detect) :           // R8 R10
    8'h00;

  // ----------------------------------------------------------------
  // Mute control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      channel_mute_bits <= CHANNELS'(mute_regs_pkg::MUTE_CTRL_RESET); // R7
    else if (wr_mute)
      channel_mute_bits <= reg_wdata[CHANNELS-1:0]; // R1
  end

  // Read data registered; zero flags are sampled live each read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end
    else
    begin
      reg_hit <= (reg_rd || reg_wr) && (sel_mute || sel_zero);
      if (reg_rd)
        reg_rdata <= next_rdata; // R9
    end
  end

  // ----------------------------------------------------------------
  // Ramp step divider: one enable pulse per STEP_CYCLES
  // ----------------------------------------------------------------
  logic [15:0] step_count;
  wire  logic  step_en = step_count == 16'(STEP_CYCLES - 1);

  always_ff @(posedge clk)
  begin
    if (rst)
      step_count <= 16'h0000;
    else
      step_count <= step_en ? 16'h0000 : 16'(step_count + 16'h0001);
  end

  // ----------------------------------------------------------------
  // Per-channel attenuators
  // ----------------------------------------------------------------
  // Unmuted channels track level changes with the same ramp (R2)
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_chan
    channel_ramp #(
      .ATTEN_W      (ATTEN_W)
    ) u_ramp (
      .clk          (clk),
      .rst          (rst),
      .step_en      (step_en),
      .mute         (channel_mute_bits[ch]),
      .target_level (level_in[ch*ATTEN_W +: ATTEN_W]),
      .atten        (atten_out[ch*ATTEN_W +: ATTEN_W])
    ); // R2 R5
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mute_write: assert property (@(posedge clk) disable iff (rst) // R1
    wr_mute |=> channel_mute_bits == $past(reg_wdata[CHANNELS-1:0]))
    else $error("mute write not stored");

  chk_mute_stable: assert property (@(posedge clk) disable iff (rst) // R11
    !wr_mute |=> $stable(channel_mute_bits))
    else $error("mute bits changed without a write");

  chk_zero_read: assert property (@(posedge clk) disable iff (rst) // R8
    (reg_rd && sel_zero) |=> reg_rdata == 8'($past(zero_detect)))
    else $error("zero flags read wrong");

  chk_mute_read: assert property (@(posedge clk) disable iff (rst) // R1
    (reg_rd && sel_mute && !reg_wr) |=> reg_rdata == 8'($past(channel_mute_bits)))
    else $error("mute bits read wrong");

  chk_reset_clear: assert property (@(posedge clk) // R7
    rst |=> channel_mute_bits == '0)
    else $error("mute bits not cleared by reset");

  chk_step_period: assert property (@(posedge clk) disable iff (rst)
    step_en |=> !step_en)
    else $error("step enable longer than one cycle");

  // Hit answers every mapped access and nothing else
  chk_hit_access: assert property (@(posedge clk) disable iff (rst) // R1
    ((reg_rd || reg_wr) && (sel_mute || sel_zero)) |=> reg_hit)
    else $error("mapped access without hit");

  chk_hit_other: assert property (@(posedge clk) disable iff (rst) // R11
    !((reg_rd || reg_wr) && (sel_mute || sel_zero)) |=> !reg_hit)
    else $error("hit without mapped access");

  // A write to the flags must leave the mute register alone
  chk_zero_ignored: assert property (@(posedge clk) disable iff (rst) // R11
    wr_zero |=> $stable(channel_mute_bits))
    else $error("zero-flag write disturbed mute bits");

  // Unmapped reads return zero so software never sees stale data
  chk_other_read: assert property (@(posedge clk) disable iff (rst) // R9
    (reg_rd && !sel_mute && !sel_zero) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Read data stands until the next read
  chk_rdata_hold: assert property (@(posedge clk) disable iff (rst) // R9
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  cov_mute_write: cover property (@(posedge clk) disable iff (rst) wr_mute && reg_wdata != 8'h00);
  cov_full_mute:  cover property (@(posedge clk) disable iff (rst) channel_mute_bits == 8'hFF);
  cov_unmute:     cover property (@(posedge clk) disable iff (rst) $fell(channel_mute_bits[0]));
  cov_zero_write: cover property (@(posedge clk) disable iff (rst) wr_zero);
  cov_zero_read:  cover property (@(posedge clk) disable iff (rst) reg_rd && sel_zero);

endmodule : soft_mute_zero_flag_regs

/* tb/soft_mute_zero_flag_regs_tb_top.sv */
// Testbench: self-checking bench for the soft-mute and zero-flag register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module soft_mute_zero_flag_regs_tb_top;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic        clk, rst, reg_wr, reg_rd, reg_hit;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, channel_mute_bits, zero_detect;
  logic [63:0] level_in, atten_out, prev_atten;
  int          err_total, checked, seed, mute_m, d, ch, g, pv;
  bit          dir_ok;
  // Short ramp period keeps a full 0 to FF ramp near 510 cycles
  soft_mute_zero_flag_regs #(.STEP_CYCLES(2)) dut_u (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .level_in(level_in), .zero_detect(zero_detect), .atten_out(atten_out),
    .channel_mute_bits(channel_mute_bits));
  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One-cycle strobe; an idle edge first, so back-to-back calls never re-drive at once
  task acc(input logic w, input logic [6:0] a, input logic [7:0] dat);
    @(posedge clk); #1;
    reg_wr = w; reg_rd = !w; reg_addr = a; reg_wdata = dat;
    @(posedge clk); #1;
    reg_wr = 1'b0; reg_rd = 1'b0;
  endtask : acc
  // Watch the ramp: every cycle each channel moves at most one step
  task ramp(input int cycles);
    for (int i = 0; i < cycles; i++)
    begin
      prev_atten = atten_out;
      @(posedge clk); #1;
      for (ch = 0; ch < 8; ch++)
      begin
        d = int'(atten_out[ch*8+:8]) - int'(prev_atten[ch*8+:8]);
        `CHK("ramp_step", 1'b1, (d <= 1 && d >= -1))
        // Each move must head toward the model's goal, never away from it
        g = mute_m[ch] ? 255 : int'(level_in[ch*8+:8]);
        pv = int'(prev_atten[ch*8+:8]);
        dir_ok = (d == 0) || (d == 1 && pv < g) || (d == -1 && pv > g);
        `CHK("ramp_dir", 1'b1, dir_ok)
      end
    end
  endtask : ramp
  // Settled outputs against the model: muted goes to FF, others to level
  task settled;
    for (ch = 0; ch < 8; ch++)
      `CHK("atten", (mute_m[ch] ? 8'hFF : level_in[ch*8+:8]), atten_out[ch*8+:8])
  endtask : settled
  task print_verdict;
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 1403; err_total = 0; checked = 0; mute_m = 0;
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 7'h00; reg_wdata = 8'h00;
    zero_detect = 8'h00;
    level_in = {$random(seed), $random(seed)};
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    // Reset state
    `CHK("mute_rst", 8'h00, channel_mute_bits)
    acc(1'b0, 7'h44, 8'h00);
    `CHK("rd_mute_rst", 8'h00, reg_rdata)
    `CHK("hit_44", 1'b1, reg_hit)
    // Zero flags, repeated writes to them, and an unmapped read
    repeat (4)
    begin
      zero_detect = 8'($random(seed));
      acc(1'b1, 7'h45, ~zero_detect);
      `CHK("hit_45w", 1'b1, reg_hit)
      acc(1'b0, 7'h45, 8'h00);
      `CHK("zero_rd", zero_detect, reg_rdata)
    end
    acc(1'b0, 7'h47, 8'h00);
    `CHK("unmapped_rd", 8'h00, reg_rdata)
    `CHK("unmapped_hit", 1'b0, reg_hit)
    ramp(600);
    settled();
    // Mute a random set, then change levels while muted
    mute_m = $random(seed) & 8'hFF;
    acc(1'b1, 7'h44, mute_m[7:0]);
    `CHK("mute_bits", mute_m[7:0], channel_mute_bits)
    acc(1'b0, 7'h44, 8'h00);
    `CHK("mute_rd", mute_m[7:0], reg_rdata)
    ramp(100);
    level_in = {$random(seed), $random(seed)};
    ramp(600);
    settled();
    // Unmute everything: back to the programmed levels by the same slope
    mute_m = 0;
    acc(1'b1, 7'h44, 8'h00);
    ramp(600);
    settled();
    `CHK("mute_clr", 8'h00, channel_mute_bits)
    // Full-scale mute: every channel ramps from its level up to FF
    mute_m = 255;
    acc(1'b1, 7'h44, 8'hFF);
    ramp(600);
    settled();
    // Mid-run reset while fully muted: bits and attenuators return to zero
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    `CHK("mute_rst2", 8'h00, channel_mute_bits)
    `CHK("atten_rst2", 64'h0, atten_out)
    mute_m = 0;
    acc(1'b1, 7'h44, 8'h00);
    ramp(600);
    settled();
    print_verdict();
  end
endmodule : soft_mute_zero_flag_regs_tb_top
